// File: shared/cloi_cfg.svh
// Purpose: Offsets, field positions, codes and reset values of the compare/output block
// Assumes: APB byte addresses, one 32-bit word per register
// Notes:   Included by its bare name
`ifndef CLOI_CFG_SVH
`define CLOI_CFG_SVH
`define CLOI_NCH        7
`define CLOI_OFF_CTRL   8'h00
`define CLOI_OFF_CCTL0  8'h04
`define CLOI_OFF_CCR0   8'h20
`define CLOI_OFF_VECT   8'h3c
`define CLOI_CTRL_GRP   1:0
`define CLOI_CTRL_OVIE  2
`define CLOI_CTRL_OVFG  3
`define CLOI_CTRL_HIZE  4
`define CLOI_CCTL_LSEL  1:0
`define CLOI_CCTL_MODE  4:2
`define CLOI_CCTL_OUT   5
`define CLOI_CCTL_IE    6
`define CLOI_CCTL_FLAG  7
`define CLOI_VEC_NONE   4'h0
`define CLOI_VEC_OVF    4'he
`define CLOI_RST_LATCH  16'h0000
`endif

// File: shared/cloi_pkg.sv
// Purpose: Types of the compare/output block
// Assumes: Constants come from cloi_cfg.svh
// Notes:   None
package cloi_pkg;
    typedef enum logic [2:0] {
        CLOI_OM_OUT, CLOI_OM_SET, CLOI_OM_TGLRST, CLOI_OM_SETRST,
        CLOI_OM_TGL, CLOI_OM_RST, CLOI_OM_TGLSET, CLOI_OM_RSTSET
    } cloi_mode_t;
    typedef struct packed {
        logic       irq_flag;
        logic       irq_en;
        logic       out_bit;
        cloi_mode_t mode;
        logic [1:0] lsel;
    } cloi_cctl_t;
    typedef struct packed {
        logic [15:0] count_value;
        logic        count_tick;
        logic        updown;
        logic        timer_clear;
        logic        overflow_evt;
    } cloi_cnt_t;
endpackage

// File: hw/cloi_top.sv
// Purpose: Compare latches, grouping, output units and vector logic
// Assumes: Counter supplies count_value with a tick on each count
// Notes:
`timescale 1ns/1ns
`include "cloi_cfg.svh"
module cloi_top (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              ce,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire cloi_pkg::cloi_cnt_t cnt,
    input  wire logic [6:0]        capture_evt,
    input  wire logic              irq0_ack,
    input  wire logic              global_irq_enable,
    input  wire logic              output_hiz_pin,
    output logic [6:0]             channel_output,
    output logic [6:0]             channel_output_oe,
    output logic                   irq_ch0,
    output logic                   irq_vector
);
    import cloi_pkg::*;

    logic [1:0]        grp_r;
    logic              ovie_r;
    logic              ovfg_r;
    logic              hize_r;
    cloi_cctl_t        cctl_r [7];
    logic [15:0]       buf_r [7];
    logic [15:0]       latch_r [7];
    logic [6:0]        wr_pend_r;
    logic [6:0]        out_r;
    logic [6:0]        oe_r;
    logic              irq0_r;
    logic              irqv_r;
    logic              pready_r;
    logic              pslverr_r;
    logic [31:0]       prdata_r;

    logic              acc;
    logic              wr;
    logic              vec_acc;
    logic              ctrl_sel;
    logic [6:0]        cctl_sel;
    logic [6:0]        ccr_sel;
    logic              mapped;
    logic [6:0]        cmp_eq;
    logic              per_eq;
    logic              zero_evt;
    logic [6:0]        ld_evt;
    logic [6:0]        load;
    logic [6:0]        flag_clr_vec;
    logic              ovf_clr_vec;
    logic [3:0]        vec;
    logic [31:0]       rd_nxt;

    assign acc      = psel & penable & pready_r;
    assign wr       = acc & pwrite;
    assign ctrl_sel = (paddr == `CLOI_OFF_CTRL);
    assign vec_acc  = acc & (paddr == `CLOI_OFF_VECT);
    assign zero_evt = cnt.count_tick & (cnt.count_value == 16'h0000);
    assign per_eq   = cmp_eq[0];
    assign mapped   = ctrl_sel | (|cctl_sel) | (|ccr_sel) | (paddr == `CLOI_OFF_VECT);

    // Load event for a given load select, judged against a channel's old latch
    function automatic logic lev(input logic [1:0] sel, input int unsigned c);
        logic r;
        r = 1'b0;
        unique case (sel)
            2'b00: r = 1'b0;
            2'b01: r = zero_evt;
            2'b10: r = zero_evt | (cnt.updown & cnt.count_tick
                       & (cnt.count_value == latch_r[0]));
            2'b11: r = cnt.count_tick & (cnt.count_value == latch_r[c]);
        endcase
        return r;
    endfunction

    // Controlling channel of a channel under the current grouping
    function automatic int unsigned ctl_of(input int unsigned c);
        int unsigned r;
        r = c;
        unique case (grp_r)
            2'b00: r = c;
            2'b01: r = (c == 0) ? 0 : ((c - 1) / 2) * 2 + 1;
            2'b10: r = (c == 0) ? 0 : ((c - 1) / 3) * 3 + 1;
            2'b11: r = 1;
        endcase
        return r;
    endfunction

    // Highest pending enabled source for the shared vector
    always_comb begin
        vec          = `CLOI_VEC_NONE;
        flag_clr_vec = 7'h00;
        ovf_clr_vec  = 1'b0;
        if (ovfg_r && ovie_r) begin
            vec         = `CLOI_VEC_OVF;
            ovf_clr_vec = vec_acc;
        end
        for (int i = 6; i >= 1; i--) begin
            if (cctl_r[i].irq_flag && cctl_r[i].irq_en) begin
                vec          = 4'(2 * i);
                ovf_clr_vec  = 1'b0;
                flag_clr_vec = 7'h00;
                flag_clr_vec[i] = vec_acc;
            end
        end
    end

    always_comb begin
        rd_nxt = 32'h0000_0000;
        if (ctrl_sel) begin
            rd_nxt[`CLOI_CTRL_GRP]  = grp_r;
            rd_nxt[`CLOI_CTRL_OVIE] = ovie_r;
            rd_nxt[`CLOI_CTRL_OVFG] = ovfg_r;
            rd_nxt[`CLOI_CTRL_HIZE] = hize_r;
        end
        if (paddr == `CLOI_OFF_VECT) begin
            rd_nxt[3:0] = vec;
        end
        for (int i = 0; i < 7; i++) begin
            if (cctl_sel[i]) begin
                rd_nxt[7:0] = cctl_r[i];
                rd_nxt[`CLOI_CCTL_OUT] = out_r[i];
            end
            if (ccr_sel[i]) begin
                rd_nxt[15:0] = buf_r[i];
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < 7; g++) begin : g_ch
            logic       bwr;
            logic       own_imm;
            logic       grp_rdy;
            logic [6:0] mem;
            logic       eq;
            logic       evt;
            logic       nout;
            cloi_cctl_t cw;

            assign cctl_sel[g] = (paddr == 8'(`CLOI_OFF_CCTL0 + 4 * g));
            assign ccr_sel[g]  = (paddr == 8'(`CLOI_OFF_CCR0 + 4 * g));
            assign bwr         = wr & ccr_sel[g];
            assign cmp_eq[g]   = cnt.count_tick & (cnt.count_value == latch_r[g]);
            assign cw          = cloi_cctl_t'(pwdata[7:0]);

            // Group members: channels sharing this channel's controller
            always_comb begin
                for (int k = 0; k < 7; k++) begin
                    mem[k] = (ctl_of(k) == ctl_of(g));
                end
            end

            // Controller (the channel itself when ungrouped) with load select at zero: load on own write
            always_comb begin
                own_imm = (cctl_r[ctl_of(g)].lsel == 2'b00);
                evt     = lev(cctl_r[ctl_of(g)].lsel, ctl_of(g));
            end
            assign grp_rdy   = &(wr_pend_r | ~mem);
            assign ld_evt[g] = evt;
            assign load[g]   = ~own_imm & grp_rdy & ld_evt[g];

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    buf_r[g]     <= `CLOI_RST_LATCH;
                    latch_r[g]   <= `CLOI_RST_LATCH;
                    wr_pend_r[g] <= 1'b0;
                end else if (ce) begin
                    if (bwr) begin
                        buf_r[g] <= pwdata[15:0];
                    end
                    if (bwr && own_imm) begin
                        latch_r[g] <= pwdata[15:0];
                    end else if (load[g]) begin
                        latch_r[g] <= buf_r[g];
                    end
                    if (own_imm || load[g]) begin
                        wr_pend_r[g] <= 1'b0;
                    end
                    if (bwr && !own_imm) begin
                        wr_pend_r[g] <= 1'b1;
                    end
                end
            end

            // Eight-mode output unit
            assign eq = cmp_eq[g];
            always_comb begin
                nout = out_r[g];
                unique case (cctl_r[g].mode)
                    CLOI_OM_OUT:    nout = cctl_r[g].out_bit;
                    CLOI_OM_SET:    nout = cnt.timer_clear ? 1'b0
                                         : (eq ? 1'b1 : out_r[g]);
                    CLOI_OM_TGLRST: nout = per_eq ? 1'b0
                                         : (eq ? ~out_r[g] : out_r[g]);
                    CLOI_OM_SETRST: nout = per_eq ? 1'b0
                                         : (eq ? 1'b1 : out_r[g]);
                    CLOI_OM_TGL:    nout = eq ? ~out_r[g] : out_r[g];
                    CLOI_OM_RST:    nout = eq ? 1'b0 : out_r[g];
                    CLOI_OM_TGLSET: nout = per_eq ? 1'b1
                                         : (eq ? ~out_r[g] : out_r[g]);
                    CLOI_OM_RSTSET: nout = per_eq ? 1'b1
                                         : (eq ? 1'b0 : out_r[g]);
                endcase
            end

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    out_r[g] <= 1'b0;
                    oe_r[g]  <= 1'b0;
                end else if (ce) begin
                    out_r[g] <= nout;
                    oe_r[g]  <= ~(hize_r & output_hiz_pin);
                end
            end

            // Control word and its interrupt flag
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    cctl_r[g] <= '0;
                end else if (ce) begin
                    if (wr && cctl_sel[g]) begin
                        cctl_r[g] <= cw;
                    end
                    if (g == 0 && irq0_ack) begin
                        cctl_r[g].irq_flag <= 1'b0;
                    end
                    if (flag_clr_vec[g]) begin
                        cctl_r[g].irq_flag <= 1'b0;
                    end
                    if (capture_evt[g] || cmp_eq[g]) begin
                        cctl_r[g].irq_flag <= 1'b1;
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            grp_r  <= 2'b00;
            ovie_r <= 1'b0;
            ovfg_r <= 1'b0;
            hize_r <= 1'b0;
        end else if (ce) begin
            if (wr && ctrl_sel) begin
                grp_r  <= pwdata[`CLOI_CTRL_GRP];
                ovie_r <= pwdata[`CLOI_CTRL_OVIE];
                ovfg_r <= pwdata[`CLOI_CTRL_OVFG];
                hize_r <= pwdata[`CLOI_CTRL_HIZE];
            end
            if (ovf_clr_vec) begin
                ovfg_r <= 1'b0;
            end
            if (cnt.overflow_evt) begin
                ovfg_r <= 1'b1;
            end
        end
    end

    // Interrupt requests, one cycle after the flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq0_r <= 1'b0;
            irqv_r <= 1'b0;
        end else if (ce) begin
            irq0_r <= cctl_r[0].irq_flag & cctl_r[0].irq_en
                    & global_irq_enable;
            irqv_r <= (vec != `CLOI_VEC_NONE) & global_irq_enable
                    & ~vec_acc;
        end
    end

    // APB slave: one wait state, answer in second access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end else if (ce) begin
            pready_r  <= psel & penable & ~pready_r;
            pslverr_r <= psel & penable & ~pready_r & ~mapped;
            if (psel && penable && !pready_r) begin
                prdata_r <= pwrite ? 32'h0000_0000 : rd_nxt;
            end
        end
    end

    assign prdata            = prdata_r;
    assign pready            = pready_r;
    assign pslverr           = pslverr_r;
    assign channel_output    = out_r;
    assign channel_output_oe = oe_r;
    assign irq_ch0           = irq0_r;
    assign irq_vector        = irqv_r;
endmodule

// File: bench/cloi_chk_sva.sv
// Purpose: Port checks of the compare/output block
// Assumes: Clock enable held high by the bench except for three cycles in t_hiz
// Notes:   Bound to cloi_top below
`timescale 1ns/1ns
`include "cloi_cfg.svh"
module cloi_chk (
    input wire logic                pclk,
    input wire logic                presetn,
    input wire logic                ce,
    input wire logic                psel,
    input wire logic                penable,
    input wire logic                pwrite,
    input wire logic [7:0]          paddr,
    input wire logic [31:0]         pwdata,
    input wire logic [31:0]         prdata,
    input wire logic                pready,
    input wire logic                pslverr,
    input wire cloi_pkg::cloi_cnt_t cnt,
    input wire logic [6:0]          capture_evt,
    input wire logic                irq0_ack,
    input wire logic                global_irq_enable,
    input wire logic                output_hiz_pin,
    input wire logic [6:0]          channel_output,
    input wire logic [6:0]          channel_output_oe,
    input wire logic                irq_ch0,
    input wire logic                irq_vector
);
    import cloi_pkg::*;
    logic acc;
    logic wr;
    logic ev;
    assign acc = psel && penable && pready;
    assign wr = acc && pwrite;
    assign ev = cnt.count_tick || cnt.timer_clear;
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    apb_wait_a: assert property (psel && !penable && ce ##1 psel && penable && ce |=> pready)
        else $error("pready missing in second access cycle");
    err_map_a: assert property (pready |-> pslverr == (paddr[7:6] != 2'b00 || paddr[1:0] != 2'b00))
        else $error("pslverr does not match the map");
    err_data_a: assert property (pready && pslverr |-> prdata == 32'h0)
        else $error("refused access returned data");
    gie_gate_a: assert property (!global_irq_enable |=> !irq_ch0 && !irq_vector)
        else $error("request without global enable");
    hiz_off_a: assert property ($fell(channel_output_oe[0]) |-> $past(output_hiz_pin))
        else $error("outputs released without hi-z pin");
    hiz_on_a: assert property (!output_hiz_pin && ce ##1 !output_hiz_pin && ce
        |=> channel_output_oe == 7'h7f) else $error("outputs not driven");
    out_edge_a: assert property ($changed(channel_output) |-> $past(ev) || $past(wr, 2))
        else $error("output changed without cause");
    vec_clr_a: assert property (acc && paddr == `CLOI_OFF_VECT |=> !irq_vector)
        else $error("vector request not dropped after access");
    ack0_a: assert property (ce && irq0_ack && !capture_evt[0] && !cnt.count_tick && !wr
        |=> ##1 !irq_ch0) else $error("channel 0 request not cleared");
endmodule
bind cloi_top cloi_chk u_chk (.*);

// File: bench/cloi_pad_model.sv
// Purpose: Pads outside the timer outputs
// Assumes: No pull on the pads
// Notes:   Released pads show the inverse of the last driven level
`timescale 1ns/1ns
module cloi_pad_model (
    input  wire logic       pclk,
    input  wire logic [6:0] drv,
    input  wire logic [6:0] drv_oe,
    output logic [6:0]      pad
);
    logic [6:0] last_r;
    always_ff @(posedge pclk) begin
        last_r <= (drv & drv_oe) | (last_r & ~drv_oe);
    end
    assign pad = (drv & drv_oe) | (~last_r & ~drv_oe);
endmodule

// File: bench/cloi_top_bench.sv
// Purpose: Self-checking bench of the compare/output block
// Assumes: APB answers before the run limit
// Notes:   Clock enable held high except for three cycles in t_hiz
`timescale 1ns/1ns
`include "cloi_cfg.svh"
module cloi_top_bench;
    import cloi_pkg::*;
    logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, se;
    logic        irq0_ack, global_irq_enable, output_hiz_pin, irq_ch0, irq_vector;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;
    logic [6:0]  capture_evt, channel_output, channel_output_oe, pad;
    cloi_cnt_t   cnt;
    int          err_total, num_checks;
    int          cyc = 0;
    cloi_top u_dut (.*);
    cloi_pad_model u_pad (.pclk(pclk), .drv(channel_output), .drv_oe(channel_output_oe),
        .pad(pad));
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chb(input string nm, input logic e, input logic g);
        chk(nm, {31'h0, e}, {31'h0, g});
    endtask
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(a, 1'b1, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(a, 1'b0, 32'h0);
        chk($sformatf("prdata@%h", a), e, q);
    endtask
    function automatic logic [7:0] cc(input int i);
        return `CLOI_OFF_CCTL0 + 8'(4 * i);
    endfunction
    function automatic logic [7:0] bf(input int i);
        return `CLOI_OFF_CCR0 + 8'(4 * i);
    endfunction
    function automatic logic f(input int m, input logic o, input logic p);
        if (p)
            return (m == 2 || m == 3) ? 1'b0 : (m >= 6 ? 1'b1 : o);
        case (m)
            2, 4, 6: return ~o;
            3:       return 1'b1;
            default: return 1'b0;
        endcase
    endfunction
    task automatic tk(input logic [15:0] v);
        @(posedge pclk);
        cnt.count_value <= v;
        cnt.count_tick <= 1'b1;
        @(posedge pclk);
        cnt.count_tick <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic clr;
        @(posedge pclk);
        cnt.timer_clear <= 1'b1;
        @(posedge pclk);
        cnt.timer_clear <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic t_reset;
        rd(`CLOI_OFF_CTRL, 32'h0);
        rd(cc(3), 32'h0);
        rd(bf(6), 32'h0);
        rd(`CLOI_OFF_VECT, 32'h0);
        apb(8'h40, 1'b0, 32'h0);
        chb("pslverr", 1'b1, se);
        chk("prdata", 32'h0, q);
        chk("oe", 32'h7f, 32'(channel_output_oe));
        $display("t_reset done");
    endtask
    task automatic t_load;
        logic [15:0] ev [1:3];
        ev = '{16'h0000, 16'h0080, 16'h0022};
        wr(bf(0), 32'h0080);
        wr(cc(1), 32'h04);
        wr(bf(1), 32'h0010);
        tk(16'h0010);
        chb("out1", 1'b1, channel_output[1]);
        rd(cc(1), 32'ha4);
        for (int s = 1; s <= 3; s++) begin
            clr;
            chb("out1", 1'b0, channel_output[1]);
            cnt.updown <= (s == 2);
            wr(cc(1), 32'(4 + s));
            wr(bf(1), 32'(16'h0020 + s));
            tk(16'(16'h0020 + s));
            chb("out1", 1'b0, channel_output[1]);
            tk(ev[s]);
            clr;
            tk(16'(16'h0020 + s));
            chb("out1", 1'b1, channel_output[1]);
        end
        cnt.updown <= 1'b0;
        $display("t_load done");
    endtask
    task automatic t_group;
        wr(bf(2), 32'h0050);
        wr(`CLOI_OFF_CTRL, 32'h1);
        wr(cc(1), 32'h01);
        wr(cc(2), 32'h04);
        wr(bf(2), 32'h0040);
        tk(16'h0000);
        tk(16'h0040);
        chb("out2", 1'b0, channel_output[2]);
        wr(bf(1), 32'h0023);
        tk(16'h0040);
        chb("out2", 1'b0, channel_output[2]);
        tk(16'h0000);
        tk(16'h0040);
        chb("out2", 1'b1, channel_output[2]);
        clr;
        wr(cc(1), 32'h00);
        wr(bf(2), 32'h0061);
        tk(16'h0061);
        chb("out2", 1'b1, channel_output[2]);
        wr(`CLOI_OFF_CTRL, 32'h0);
        $display("t_group done");
    endtask
    task automatic t_group_wide;
        int c;
        c = 0;
        wr(bf(6), 32'h007f);
        wr(cc(6), 32'h04);
        for (int g = 2; g <= 3; g++) begin
            c = (g == 2) ? 4 : 1;
            clr;
            wr(`CLOI_OFF_CTRL, 32'(g));
            wr(cc(c), 32'h01);
            for (int i = 0; i < 7; i++)
                if (i != c && (g == 3 || i != 0))
                    wr(bf(i), 32'(16'h0070 + g));
            tk(16'h0000);
            tk(16'(16'h0070 + g));
            chb("out6", 1'b0, channel_output[6]);
            wr(bf(c), 32'(16'h0070 + g));
            tk(16'h0000);
            tk(16'(16'h0070 + g));
            chb("out6", 1'b1, channel_output[6]);
        end
        wr(`CLOI_OFF_CTRL, 32'h0);
        wr(cc(1), 32'h00);
        wr(bf(0), 32'h0080);
        $display("t_group_wide done");
    endtask
    task automatic t_modes;
        logic e;
        e = 1'b0;
        wr(bf(3), 32'h0030);
        for (int m = 2; m <= 7; m++) begin
            cnt.updown <= (m > 5);
            wr(cc(3), 32'h1c);
            wr(cc(3), 32'(m << 2));
            for (int k = 0; k < 3; k++) begin
                e = f(m, e, k == 0);
                tk(k == 0 ? 16'h0080 : 16'h0030);
                chb("out3", e, channel_output[3]);
            end
        end
        cnt.updown <= 1'b0;
        $display("t_modes done");
    endtask
    task automatic t_irq;
        for (int i = 1; i < 7; i++)
            wr(cc(i), (i == 2 || i == 5) ? 32'h40 : 32'h00);
        wr(`CLOI_OFF_CTRL, 32'h4);
        wr(cc(0), 32'h40);
        global_irq_enable <= 1'b1;
        capture_evt <= 7'h35;
        cnt.overflow_evt <= 1'b1;
        @(posedge pclk);
        capture_evt <= 7'h00;
        cnt.overflow_evt <= 1'b0;
        repeat (2) @(posedge pclk);
        chb("irq_ch0", 1'b1, irq_ch0);
        chb("irq_vector", 1'b1, irq_vector);
        rd(`CLOI_OFF_VECT, 32'h4);
        repeat (2) @(posedge pclk);
        chb("irq_vector", 1'b1, irq_vector);
        wr(`CLOI_OFF_VECT, 32'h0);
        rd(`CLOI_OFF_VECT, 32'he);
        rd(`CLOI_OFF_VECT, 32'h0);
        irq0_ack <= 1'b1;
        @(posedge pclk);
        irq0_ack <= 1'b0;
        repeat (2) @(posedge pclk);
        chb("irq_ch0", 1'b0, irq_ch0);
        chb("irq_vector", 1'b0, irq_vector);
        wr(cc(0), 32'he0);
        repeat (2) @(posedge pclk);
        chb("irq_ch0", 1'b1, irq_ch0);
        chb("out0", 1'b1, channel_output[0]);
        $display("t_irq done");
    endtask
    task automatic t_hiz;
        wr(`CLOI_OFF_CTRL, 32'h10);
        output_hiz_pin <= 1'b1;
        repeat (3) @(posedge pclk);
        chk("oe", 32'h0, 32'(channel_output_oe));
        chb("pad0", 1'b0, pad[0]);
        output_hiz_pin <= 1'b0;
        repeat (3) @(posedge pclk);
        chk("oe", 32'h7f, 32'(channel_output_oe));
        chb("pad0", 1'b1, pad[0]);
        ce <= 1'b0;
        output_hiz_pin <= 1'b1;
        repeat (3) @(posedge pclk);
        chk("oe", 32'h7f, 32'(channel_output_oe));
        output_hiz_pin <= 1'b0;
        ce <= 1'b1;
        $display("t_hiz done");
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_total++;
            close_out();
        end
    end
    initial begin
        presetn = 1'b0;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        cnt = '0;
        capture_evt = 7'h00;
        irq0_ack = 1'b0;
        global_irq_enable = 1'b0;
        output_hiz_pin = 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_load;
        t_group;
        t_group_wide;
        t_modes;
        t_irq;
        t_hiz;
        close_out();
    end
endmodule
